// ### logic/lowside_pwm_pair_lock.sv
// Four low-side PWM channels with pair locking and loop command sources.
// Summary of operation
// R1 - PWM only while channel enable is on; a locked follower uses its master's enable.
// R2 - Pair A lock: channel 2 follows channel 1.
// R3 - Pair B lock: channel 4 follows channel 3.
// R4 - Pair A lock changes only when both disabled.
// R5 - Pair B lock changes only when both disabled.
// R6 - Locked pair outputs switch on identical edges.
// R7 - Channels 1, 3 pick host, metering or bleed.
// R8 - Timing format picks frequency or period.
// R9 - Width format picks duty or pulse width.
// R10 - Frequency format repeats at given hertz.
// R11 - Duty format holds output given percent.
// R12 - Period format repeats at given milliseconds.
// R13 - Width format holds output given milliseconds.
// R14 - Host locks pairs for loop-driven channels.
// R15 - Disabled channel off unless locked to an enabled master, restarts when enabled.
// R16 - On-time clamped to one full period.
`timescale 1ns/1ps
`default_nettype none
`include "lowside_pwm_map.svh"

module lowside_pwm_pair_lock #(
   // Clock cycles in one millisecond.
   parameter logic [31:0] CYC_PER_MS = 32'(`CYC_PER_MS),
   // Clock cycles in one second.
   parameter logic [31:0] CYC_PER_SEC = 32'(`CYC_PER_SEC)
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Inlet metering loop command.
   input wire logic [15:0] meter_freq,
   input wire logic [6:0] meter_duty,
   // Pressure bleed loop command.
   input wire logic [15:0] bleed_freq,
   input wire logic [6:0] bleed_duty,
   // Low-side drive, high means conducting.
   output logic [3:0] lowside_out
);

   // ==========================================
   // State and derived timing

   // Registered state and its next value.
   lowside_pwm_pkg::state_s st_reg;
   lowside_pwm_pkg::state_s st_next;
   // Period of each channel in clock cycles.
   logic [3:0][31:0] per_cyc;
   // On-time of each channel in clock cycles.
   logic [3:0][31:0] on_cyc;

   // ==========================================
   // Per-channel period and on-time

   // Both figures are worked out combinationally from the settings, so a
   // new setting takes hold at once; the variable divider is large but
   // keeps the counter a plain compare against whole cycles.
   always_comb begin
      logic [15:0] f;
      logic [6:0] d;
      logic tf;
      logic wf;
      logic [39:0] prod;
      lowside_pwm_pkg::src_e src;
      f = '0;
      d = '0;
      tf = 1'b0;
      wf = 1'b0;
      prod = '0;
      src = lowside_pwm_pkg::SRC_HOST;
      per_cyc = '0;
      on_cyc = '0;
      for (int i = 0; i < 4; i++) begin
         f = st_reg.freq[i];
         d = st_reg.duty[i];
         tf = st_reg.tfmt[i];
         wf = st_reg.wfmt[i];
         src = (i == 0) ? st_reg.src1 : st_reg.src3;
         // R7 loop command source
         // Loop commands arrive as frequency and duty, so they force both
         // formats; only channels one and three can take them.
         if ((i == 0) || (i == 2)) begin
            if (src == lowside_pwm_pkg::SRC_METER) begin
               f = meter_freq;
               d = meter_duty;
               tf = 1'b0;
               wf = 1'b0;
            end else if (src == lowside_pwm_pkg::SRC_BLEED) begin
               f = bleed_freq;
               d = bleed_duty;
               tf = 1'b0;
               wf = 1'b0;
            end
         end
         // R8 timing format select
         if (tf) begin
            // R12 period in milliseconds
            per_cyc[i] = 32'(st_reg.period[i] * CYC_PER_MS);
         end else if (f != 16'h0000) begin
            // R10 frequency in hertz
            per_cyc[i] = CYC_PER_SEC / {16'h0000, f};
         end else begin
            // A zero frequency leaves the channel idle.
            per_cyc[i] = '0;
         end
         // R9 width format select
         if (wf) begin
            // R13 pulse width in milliseconds
            prod = 40'(st_reg.width[i] * CYC_PER_MS);
         end else begin
            // R11 duty cycle percentage
            prod = (40'(per_cyc[i]) * 40'(d)) / 40'(`PCT_FULL);
         end
         // R16 clamp to one period
         on_cyc[i] = (prod > 40'(per_cyc[i])) ? per_cyc[i] : prod[31:0];
      end
   end

   // ==========================================
   // Next-state logic

   // Register writes, read data and the PWM counters all feed one copy
   // of the state that the clocked process below stores.
   always_comb begin
      logic own;
      logic [1:0] m;
      logic [31:0] inc;
      own = 1'b1;
      m = '0;
      inc = '0;
      st_next = st_reg;
      // Read data stand for one cycle only.
      st_next.rdata = '0;

      // PWM counters and outputs.
      for (int i = 0; i < 4; i++) begin
         // R2 channel two follows one
         // R3 channel four follows three
         own = !(((i == 1) && st_reg.lock_a) || ((i == 3) && st_reg.lock_b));
         m = own ? 2'(i) : 2'(i - 1);
         inc = st_reg.cnt[i] + 32'h0000_0001;
         // R15 restart from zero
         if (!st_reg.en[i] || !own) begin
            st_next.cnt[i] = '0;
         end else if (inc >= per_cyc[i]) begin
            st_next.cnt[i] = '0;
         end else begin
            st_next.cnt[i] = inc;
         end
         // R1 drive only when channel m (self or master) is enabled
         // R6 identical edges from master
         st_next.out[i] = st_reg.en[m] && (st_reg.cnt[m] < on_cyc[m]);
      end

      // Register writes; unmapped offsets are ignored.
      if (wr_en) begin
         case (addr)
            `REG_CTRL: begin
               st_next.en = wr_data[`CTRL_EN_LSB +: 4];
               // R4 pair A lock guard
               if (!(st_reg.en[0] || st_reg.en[1])) begin
                  st_next.lock_a = wr_data[`CTRL_LOCK_A_BIT];
               end
               // R5 pair B lock guard
               if (!(st_reg.en[2] || st_reg.en[3])) begin
                  st_next.lock_b = wr_data[`CTRL_LOCK_B_BIT];
               end
               st_next.src1 = lowside_pwm_pkg::src_e'(wr_data[`CTRL_SRC1_LSB +: 2]);
               st_next.src3 = lowside_pwm_pkg::src_e'(wr_data[`CTRL_SRC3_LSB +: 2]);
            end
            `REG_FMT: begin
               st_next.tfmt = wr_data[`FMT_TIMING_LSB +: 4];
               st_next.wfmt = wr_data[`FMT_WIDTH_LSB +: 4];
            end
            default: begin
               // Per-channel settings sit in pairs of words.
               for (int i = 0; i < 4; i++) begin
                  if (addr == 8'(`REG_CH_TIME + `REG_CH_STRIDE * i)) begin
                     st_next.freq[i] = wr_data[`TIME_FREQ_LSB +: 16];
                     st_next.period[i] = wr_data[`TIME_PERIOD_LSB +: 16];
                  end
                  if (addr == 8'(`REG_CH_WIDTH + `REG_CH_STRIDE * i)) begin
                     st_next.duty[i] = wr_data[`WIDTH_DUTY_LSB +: 7];
                     st_next.width[i] = wr_data[`WIDTH_PW_LSB +: 16];
                  end
               end
            end
         endcase
      end

      // Register reads; unmapped offsets read as zero.
      if (rd_en) begin
         case (addr)
            `REG_CTRL: begin
               st_next.rdata[`CTRL_EN_LSB +: 4] = st_reg.en;
               st_next.rdata[`CTRL_LOCK_A_BIT] = st_reg.lock_a;
               st_next.rdata[`CTRL_LOCK_B_BIT] = st_reg.lock_b;
               st_next.rdata[`CTRL_SRC1_LSB +: 2] = st_reg.src1;
               st_next.rdata[`CTRL_SRC3_LSB +: 2] = st_reg.src3;
            end
            `REG_FMT: begin
               st_next.rdata[`FMT_TIMING_LSB +: 4] = st_reg.tfmt;
               st_next.rdata[`FMT_WIDTH_LSB +: 4] = st_reg.wfmt;
            end
            `REG_STAT: begin
               // Live output levels, useful to watch a pair in step.
               st_next.rdata[3:0] = st_reg.out;
            end
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (addr == 8'(`REG_CH_TIME + `REG_CH_STRIDE * i)) begin
                     st_next.rdata[`TIME_FREQ_LSB +: 16] = st_reg.freq[i];
                     st_next.rdata[`TIME_PERIOD_LSB +: 16] = st_reg.period[i];
                  end
                  if (addr == 8'(`REG_CH_WIDTH + `REG_CH_STRIDE * i)) begin
                     st_next.rdata[`WIDTH_DUTY_LSB +: 7] = st_reg.duty[i];
                     st_next.rdata[`WIDTH_PW_LSB +: 16] = st_reg.width[i];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================
   // State register

   // Reset leaves every channel disabled, unlocked and host-sourced.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_reg <= '0;
         for (int i = 0; i < 4; i++) begin
            st_reg.freq[i] <= `RST_FREQ;
            st_reg.duty[i] <= `RST_DUTY;
            st_reg.period[i] <= `RST_PERIOD;
            st_reg.width[i] <= `RST_WIDTH;
         end
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign rd_data = st_reg.rdata;
   assign lowside_out = st_reg.out;

   // ==========================================
   // Assertions

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // A disabled channel one is dark on the next edge.
   chk_off_disabled: assert property ( // R1
      !st_reg.en[0] |=> !lowside_out[0]
   ) else $error("Channel one drove while disabled.");

   // Locked channel two mirrors channel one.
   chk_lock_a_mirror: assert property ( // R2
      st_reg.lock_a && $past(st_reg.lock_a) |-> lowside_out[1] == lowside_out[0]
   ) else $error("Channel two left step with channel one.");

   // Locked channel four mirrors channel three.
   chk_lock_b_mirror: assert property ( // R3
      st_reg.lock_b && $past(st_reg.lock_b) |-> lowside_out[3] == lowside_out[2]
   ) else $error("Channel four left step with channel three.");

   // Pair A lock holds while either channel runs.
   chk_lock_a_hold: assert property ( // R4
      (st_reg.en[0] || st_reg.en[1]) |=> $stable(st_reg.lock_a)
   ) else $error("Pair A lock changed while enabled.");

   // Pair B lock holds while either channel runs.
   chk_lock_b_hold: assert property ( // R5
      (st_reg.en[2] || st_reg.en[3]) |=> $stable(st_reg.lock_b)
   ) else $error("Pair B lock changed while enabled.");

   // Counter restarts from zero after a disable.
   chk_restart_zero: assert property ( // R15
      !st_reg.en[0] |=> st_reg.cnt[0] == 32'h0000_0000
   ) else $error("Channel one counter not cleared.");

   // On-time never exceeds one period.
   chk_ontime_clamp: assert property ( // R16
      on_cyc[0] <= per_cyc[0] && on_cyc[2] <= per_cyc[2]
   ) else $error("On-time above one period.");

   // The counter wraps at the end of each period.
   chk_period_wrap: assert property ( // R10
      st_reg.en[0] && per_cyc[0] > 32'h1 && st_reg.cnt[0] == per_cyc[0] - 32'h1
      ##0 $stable(per_cyc[0])
      |=> st_reg.cnt[0] == 32'h0000_0000
   ) else $error("Channel one period wrap missed.");

   // Read data answer one cycle after the strobe and then clear.
   chk_read_pulse: assert property (
      !rd_en |=> rd_data == 32'h0000_0000
   ) else $error("Read data outside the answer cycle.");

   // Metering source takes over channel one's period.
   chk_meter_src: assert property ( // R7
      st_reg.src1 == lowside_pwm_pkg::SRC_METER && meter_freq != 16'h0000
      |-> per_cyc[0] == CYC_PER_SEC / {16'h0000, meter_freq}
   ) else $error("Metering command not applied.");

   // Bleed source takes over channel three's period.
   chk_bleed_src: assert property ( // R7
      st_reg.src3 == lowside_pwm_pkg::SRC_BLEED && bleed_freq != 16'h0000
      |-> per_cyc[2] == CYC_PER_SEC / {16'h0000, bleed_freq}
   ) else $error("Bleed command not applied.");

   // A disabled channel three is dark on the next edge.
   chk_ch3_off: assert property ( // R1
      !st_reg.en[2] |=> !lowside_out[2]
   ) else $error("Channel three drove while disabled.");

   // A locked channel two keeps its own counter parked at zero.
   chk_follow_a_idle: assert property ( // R2
      st_reg.lock_a |=> st_reg.cnt[1] == 32'h0000_0000
   ) else $error("Channel two ran its own timing while locked.");

   // A locked channel four keeps its own counter parked at zero.
   chk_follow_b_idle: assert property ( // R3
      st_reg.lock_b |=> st_reg.cnt[3] == 32'h0000_0000
   ) else $error("Channel four ran its own timing while locked.");

   // Coverage of main scenarios.
   cov_pair_a_run: cover property (
      st_reg.lock_a && st_reg.en[0] && lowside_out[0] && lowside_out[1]
   );
   cov_bleed_src: cover property (
      st_reg.src3 == lowside_pwm_pkg::SRC_BLEED && lowside_out[2]
   );
   cov_lock_refused: cover property (
      wr_en && addr == `REG_CTRL && st_reg.en[0] && wr_data[`CTRL_LOCK_A_BIT] != st_reg.lock_a
   );
   cov_width_mode: cover property (
      st_reg.wfmt[1] && st_reg.tfmt[1] && $fell(lowside_out[1])
   );

endmodule : lowside_pwm_pair_lock
`default_nettype wire

// ### logic/lowside_pwm_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef LOWSIDE_PWM_MAP_SVH
`define LOWSIDE_PWM_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_FMT 8'h04
`define REG_STAT 8'h08
`define REG_CH_TIME 8'h10
`define REG_CH_WIDTH 8'h14
`define REG_CH_STRIDE 8'h08
// ==========================================
// Field positions
`define CTRL_EN_LSB 0
`define CTRL_LOCK_A_BIT 4
`define CTRL_LOCK_B_BIT 5
`define CTRL_SRC1_LSB 8
`define CTRL_SRC3_LSB 10
`define FMT_TIMING_LSB 0
`define FMT_WIDTH_LSB 4
`define TIME_FREQ_LSB 0
`define TIME_PERIOD_LSB 16
`define WIDTH_DUTY_LSB 0
`define WIDTH_PW_LSB 16
// ==========================================
// Reset values
`define RST_FREQ 16'h0064
`define RST_DUTY 7'h32
`define RST_PERIOD 16'h000a
`define RST_WIDTH 16'h0005
// ==========================================
// Timing
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define SEC_NS 1000000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define CYC_PER_SEC (`SEC_NS / `CLK_PERIOD_NS)
`define PCT_FULL 100
`endif

// ### logic/lowside_pwm_pkg.sv
// Types shared by the low-side PWM block.
`default_nettype none
package lowside_pwm_pkg;
   // Command source of channels one and three.
   typedef enum logic [1:0] {
      SRC_HOST = 2'b00,
      SRC_METER = 2'b01,
      SRC_BLEED = 2'b10
   } src_e;

   // Whole register state of the block.
   typedef struct packed {
      logic [3:0] en;
      logic lock_a;
      logic lock_b;
      src_e src1;
      src_e src3;
      logic [3:0] tfmt;
      logic [3:0] wfmt;
      logic [3:0][15:0] freq;
      logic [3:0][6:0] duty;
      logic [3:0][15:0] period;
      logic [3:0][15:0] width;
      logic [3:0][31:0] cnt;
      logic [3:0] out;
      logic [31:0] rdata;
   } state_s;
endpackage : lowside_pwm_pkg
`default_nettype wire

// ### tb/pwm_load_model.sv
// Solenoid load model that measures on-time and repeat period of each low-side drive.
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Low-side drives seen by the four valve coils.
   input wire logic [3:0] drive,
   // Last complete conducting run and rise-to-rise period, in cycles.
   output logic [3:0][15:0] on_len,
   output logic [3:0][15:0] per_len
);
   logic [3:0] prev; // Drive level at the previous edge.
   logic [3:0][15:0] hcnt; // Length of the current conducting run.
   logic [3:0][15:0] pcnt; // Cycles since the last turn-on.

   // ==========================================
   // Measurement
   // A coil reports a run at each turn-off and a period at each turn-on; the first turn-on reports cycles counted since reset.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prev <= 4'h0;
         hcnt <= '0;
         pcnt <= '0;
         on_len <= '0;
         per_len <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            prev[i] <= drive[i];
            hcnt[i] <= drive[i] ? hcnt[i] + 16'h0001 : 16'h0000;
            pcnt[i] <= (drive[i] && !prev[i]) ? 16'h0001 : pcnt[i] + 16'h0001;
            // A turn-on closes one period.
            if (drive[i] && !prev[i]) begin
               per_len[i] <= pcnt[i];
            end
            // A turn-off closes one conducting run.
            if (!drive[i] && prev[i]) begin
               on_len[i] <= hcnt[i];
            end
         end
      end
   end
endmodule : pwm_load_model
`default_nettype wire

// ### tb/lowside_pwm_pair_lock_test.sv
// Self-checking bench for the four-channel low-side PWM block with pair locking.
`timescale 1ns/1ps
`default_nettype none
`include "lowside_pwm_map.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module lowside_pwm_pair_lock_test;
   // Short counts keep the run brief: 10 cycles a millisecond, 10000 a second.
   localparam logic [31:0] MS = 32'h0000000a;
   localparam logic [31:0] SEC = 32'h00002710;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h00000000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic [15:0] meter_freq = 16'h0000;
   logic [6:0] meter_duty = 7'h00;
   logic [15:0] bleed_freq = 16'h0000;
   logic [6:0] bleed_duty = 7'h00;
   logic [3:0] lowside_out;
   logic [3:0][15:0] on_len;
   logic [3:0][15:0] per_len;
   int n_errors = 0;
   int n_checks = 0;

   lowside_pwm_pair_lock #(.CYC_PER_MS(MS), .CYC_PER_SEC(SEC)) uut (
      .sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .meter_freq(meter_freq), .meter_duty(meter_duty),
      .bleed_freq(bleed_freq), .bleed_duty(bleed_duty), .lowside_out(lowside_out));

   pwm_load_model load (.sys_clk(sys_clk), .reset(reset), .drive(lowside_out),
      .on_len(on_len), .per_len(per_len));

   // 100 ns clock.
   always #50 sys_clk = ~sys_clk;

   // ==========================================
   // Bus and measurement helpers
   // A write is one strobe cycle; returning on the release edge leaves a gap before the next.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so it is taken just after that edge.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      `CHK(nm, e, rd_data)
   endtask : rd_chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_cyc

   task automatic meas(input int c, input logic [15:0] on, input logic [15:0] per);
      `CHK("on time", on, on_len[c])
      `CHK("period", per, per_len[c])
   endtask : meas

   // Compares the two drives of a pair at every cycle.
   task automatic instep(input int a, input int b);
      int bad = 0;
      repeat (200) begin
         wait_cyc(1);
         if (lowside_out[a] !== lowside_out[b]) bad++;
      end
      `CHK("pair in step", 0, bad)
   endtask : instep

   // ==========================================
   // Scenarios
   task automatic t_reset;
      `CHK("outputs at reset", 4'h0, lowside_out)
      rd_chk(`REG_CTRL, 32'h00000000, "ctrl");
      rd_chk(`REG_FMT, 32'h00000000, "fmt");
      for (int k = 0; k < 4; k++) begin
         rd_chk(8'(`REG_CH_TIME + k * 8), {`RST_PERIOD, `RST_FREQ}, "time");
         rd_chk(8'(`REG_CH_WIDTH + k * 8), {`RST_WIDTH, 9'h000, `RST_DUTY}, "width");
      end
      rd_chk(8'h40, 32'h00000000, "unmapped");
   endtask : t_reset

   // Channel one at 100 Hz, 50 percent: 100 cycles a period, 50 on.
   task automatic t_freq_duty;
      wr(`REG_CTRL, 32'h00000001);
      wait_cyc(250);
      meas(0, 16'h0032, 16'h0064);
      `CHK("idle channel", 1'b0, lowside_out[1])
      wr(`REG_CTRL, 32'h00000000);
      wait_cyc(1);
      `CHK("off when disabled", 1'b0, lowside_out[0])
      wr(`REG_CTRL, 32'h00000001);
      wait_cyc(1);
      `CHK("restart on enable", 1'b1, lowside_out[0])
      wr(`REG_CTRL, 32'h00000000);
   endtask : t_freq_duty

   // Channel three by period 3 ms and width 1 ms, then a width longer than the period.
   task automatic t_period_width;
      wr(`REG_FMT, 32'h00000044);
      wr(8'h20, {16'h0003, 16'h0064});
      wr(8'h24, {16'h0001, 16'h0032});
      wr(`REG_CTRL, 32'h00000004);
      wait_cyc(100);
      meas(2, 16'h000a, 16'h001e);
      wr(8'h24, {16'h0005, 16'h0032});
      wait_cyc(40);
      // clamp holds drive on at every cycle.
      repeat (60) begin
         wait_cyc(1);
         `CHK("held on", 1'b1, lowside_out[2])
      end
      `CHK("clamped on", 1'b1, lowside_out[2])
      rd_chk(`REG_STAT, 32'h00000004, "status");
      wr(`REG_CTRL, 32'h00000000);
      wr(`REG_FMT, 32'h00000000);
   endtask : t_period_width

   // Channel two gets its own 400 Hz, which the lock must hide.
   task automatic t_lock_a;
      wr(`REG_CH_TIME + 8'h08, {16'h000a, 16'h0190});
      wr(`REG_CTRL, 32'h00000002);
      wr(`REG_CTRL, 32'h00000012);
      rd_chk(`REG_CTRL, 32'h00000002, "lock a refused");
      wr(`REG_CTRL, 32'h00000000);
      wr(`REG_CTRL, 32'h00000011);
      rd_chk(`REG_CTRL, 32'h00000011, "lock a set");
      instep(0, 1);
      meas(1, 16'h0032, 16'h0064);
      wr(`REG_CTRL, 32'h00000000);
      rd_chk(`REG_CTRL, 32'h00000010, "lock a held");
      wr(`REG_CTRL, 32'h00000000);
      rd_chk(`REG_CTRL, 32'h00000000, "lock a cleared");
   endtask : t_lock_a

   // Channel three from both loops, locked with channel four as recommended.
   task automatic t_lock_b;
      @(posedge sys_clk);
      meter_freq <= 16'h00c8;
      meter_duty <= 7'h14;
      bleed_freq <= 16'h01f4;
      bleed_duty <= 7'h4b;
      wr(`REG_CTRL, 32'h00000424);
      instep(2, 3);
      meas(2, 16'h000a, 16'h0032);
      meas(3, 16'h000a, 16'h0032);
      wr(`REG_CTRL, 32'h00000824);
      wait_cyc(100);
      meas(2, 16'h000f, 16'h0014);
      meas(3, 16'h000f, 16'h0014);
      wr(`REG_CTRL, 32'h00000804);
      rd_chk(`REG_CTRL, 32'h00000824, "lock b held");
      // Channel one alone from the metering loop: 200 Hz, 20 percent.
      wr(`REG_CTRL, 32'h00000101);
      wait_cyc(100);
      meas(0, 16'h000a, 16'h0032);
      wr(`REG_CTRL, 32'h00000000);
   endtask : t_lock_b

   // ==========================================
   // Verdict
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // A hang is cut short well beyond the longest scenario.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_freq_duty();
      t_period_width();
      t_lock_a();
      t_lock_b();
      finish_test();
   end
endmodule : lowside_pwm_pair_lock_test
`default_nettype wire
